// file: cmt_capture.sv
// Timer package (constants, types) and one capture channel module
//
// Contract
// - A 32-bit prescaler's terminal tick advances the 32-bit timer count once.
// - Prescaler and timer count run on the timer clock; all timing in its periods.
// - Each of four capture channels snapshots the count on an input change.
// - A capture raises its interrupt request only when that channel is enabled.
// - Four 32-bit match values are compared with the timer count on each prescaler tick.
// - Continuous mode: counting proceeds at a match, interrupt if enabled.
// - Stop mode: a match halts the timer count, interrupt if enabled.
// - Reset mode: a match returns the count to zero, interrupt if enabled.
// - Each match output goes low, high, toggles or holds on its match.
// - Flags, captures, outputs and counters all run on the one timer clock.
package cmt_pkg;
   localparam int CNT_W  = 32;
   localparam int NUM_CH = 4;
   localparam int NUM_FL = 2 * NUM_CH;
   localparam logic [CNT_W-1:0]  CNT_RST  = 32'h0000_0000;
   localparam logic [NUM_FL-1:0] FLAG_RST = 8'h00;
   localparam logic [NUM_CH-1:0] MOUT_RST = 4'h0;
   localparam int FL_MATCH_LSB = 0;
   localparam int FL_CAP_LSB   = NUM_CH;

   // Match output action
   typedef enum logic [1:0] {
      CMT_MACT_NONE   = 2'h0,
      CMT_MACT_LOW    = 2'h1,
      CMT_MACT_HIGH   = 2'h2,
      CMT_MACT_TOGGLE = 2'h3
   } cmt_mact_t;

   typedef struct packed {
      logic      irq_en;
      logic      stop;
      logic      reset;
      cmt_mact_t ext_act;
   } cmt_match_cfg_t;

   typedef struct packed {
      logic irq_en;
      logic rise;
      logic fall;
   } cmt_cap_cfg_t;
endpackage

`timescale 1ns/1ps

module cmt_capture (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   // Configuration and count
   input  wire cmt_pkg::cmt_cap_cfg_t    cfg,
   input  wire logic [cmt_pkg::CNT_W-1:0] count,
   // Pin and results
   input  wire logic                     pin,
   output logic [cmt_pkg::CNT_W-1:0]      value,
   output logic                          event_pulse
);
   logic sync1;
   logic sync2;
   logic prev;
   wire  rise_seen;
   wire  fall_seen;
   wire  take;

   // Two-stage synchroniser, then a history stage; edges compare stages two and three
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev  <= 1'b0;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   // Edge selection
   assign rise_seen = sync2 & ~prev;
   assign fall_seen = ~sync2 & prev;
   assign take      = (rise_seen & cfg.rise) | (fall_seen & cfg.fall);
   assign event_pulse = take;

   // Snapshot of the running count
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         value <= cmt_pkg::CNT_RST;
      end else if (take) begin
         value <= count;
      end
   end

   a_cap_snapshot: assert property (@(posedge sys_clk) disable iff (rst)
      take |=> value == $past(count)) else $error("capture missed count");
endmodule // cmt_capture

// file: cmt_timer.sv
// Capture and match timer top level
`timescale 1ns/1ps

module cmt_timer (
   // Clock and reset (timer clock)
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   // Control
   input  wire logic                           counter_enable,
   input  wire logic                           counter_reset,
   input  wire logic [cmt_pkg::CNT_W-1:0]      prescale_max,
   input  wire logic [cmt_pkg::CNT_W-1:0]      match_value [cmt_pkg::NUM_CH],
   input  wire cmt_pkg::cmt_match_cfg_t        match_cfg   [cmt_pkg::NUM_CH],
   input  wire cmt_pkg::cmt_cap_cfg_t          cap_cfg     [cmt_pkg::NUM_CH],
   input  wire logic [cmt_pkg::NUM_FL-1:0]     irq_clear,
   // Status
   output logic [cmt_pkg::CNT_W-1:0]           timer_count,
   output logic [cmt_pkg::CNT_W-1:0]           prescale_count,
   output logic [cmt_pkg::CNT_W-1:0]           cap_value   [cmt_pkg::NUM_CH],
   output logic [cmt_pkg::NUM_FL-1:0]          irq_flags,
   output logic                                halted,
   output logic                                irq_req,
   // Pins
   input  wire logic [cmt_pkg::NUM_CH-1:0]     capture_input,
   output logic [cmt_pkg::NUM_CH-1:0]          match_output
);
   wire                          running;
   wire                          tick;
   wire [cmt_pkg::NUM_CH-1:0]    hit;
   wire [cmt_pkg::NUM_CH-1:0]    hit_stop;
   wire [cmt_pkg::NUM_CH-1:0]    hit_reset;
   wire [cmt_pkg::NUM_CH-1:0]    cap_evt;
   wire [cmt_pkg::NUM_FL-1:0]    flag_set;
   wire [cmt_pkg::NUM_FL-1:0]    flag_en;
   wire [cmt_pkg::CNT_W-1:0]     next_prescale;
   logic [cmt_pkg::CNT_W-1:0]    next_timer;
   logic [cmt_pkg::NUM_CH-1:0]   next_mout;

   // Prescaler wraps at its programmed maximum; that wrap is the timer tick
   assign running       = counter_enable & ~halted & ~counter_reset;
   assign tick          = running & (prescale_count == prescale_max);
   assign next_prescale = tick ? cmt_pkg::CNT_RST : prescale_count + 32'h0000_0001;

   always_ff @(posedge sys_clk) begin
      if (rst || counter_reset) begin
         prescale_count <= cmt_pkg::CNT_RST;
      end else if (running) begin
         prescale_count <= next_prescale;
      end
   end

   // Matches are qualified by the tick so each value fires once per visit
   genvar g;
   generate
      for (g = 0; g < cmt_pkg::NUM_CH; g++) begin : g_ch
         assign hit[g]       = tick & (timer_count == match_value[g]);
         assign hit_stop[g]  = hit[g] & match_cfg[g].stop;
         assign hit_reset[g] = hit[g] & match_cfg[g].reset;
         assign flag_en[cmt_pkg::FL_MATCH_LSB + g] = match_cfg[g].irq_en;
         assign flag_en[cmt_pkg::FL_CAP_LSB + g]   = cap_cfg[g].irq_en;

         // Output action per channel
         always_comb begin
            next_mout[g] = match_output[g];
            if (hit[g]) begin
               unique case (match_cfg[g].ext_act)
                  cmt_pkg::CMT_MACT_NONE:   next_mout[g] = match_output[g];
                  cmt_pkg::CMT_MACT_LOW:    next_mout[g] = 1'b0;
                  cmt_pkg::CMT_MACT_HIGH:   next_mout[g] = 1'b1;
                  cmt_pkg::CMT_MACT_TOGGLE: next_mout[g] = ~match_output[g];
               endcase
            end
         end

         cmt_capture u_cap (
            .sys_clk     (sys_clk),
            .rst         (rst),
            .cfg         (cap_cfg[g]),
            .count       (timer_count),
            .pin         (capture_input[g]),
            .value       (cap_value[g]),
            .event_pulse (cap_evt[g])
         );
      end
   endgenerate

   assign flag_set = {cap_evt, hit};

   // Timer count: reset on match wins over increment; stop holds the count
   always_comb begin
      next_timer = timer_count;
      if (tick) begin
         if (|hit_reset) begin
            next_timer = cmt_pkg::CNT_RST;
         end else if (|hit_stop) begin
            next_timer = timer_count;
         end else begin
            next_timer = timer_count + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || counter_reset) begin
         timer_count <= cmt_pkg::CNT_RST;
      end else begin
         timer_count <= next_timer;
      end
   end

   // Halt latch; software releases it by dropping the enable
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         halted <= 1'b0;
      end else if (|hit_stop) begin
         halted <= 1'b1;
      end else if (!counter_enable) begin
         halted <= 1'b0;
      end
   end

   // Sticky flags: a new event in the clear cycle keeps the flag set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_flags    <= cmt_pkg::FLAG_RST;
         match_output <= cmt_pkg::MOUT_RST;
      end else begin
         irq_flags    <= flag_set | (irq_flags & ~irq_clear);
         match_output <= next_mout;
      end
   end

   // Disabled flags still record events but do not raise the request
   assign irq_req = |(irq_flags & flag_en);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Prescaler and timer count
   a_tick_advance: assert property (
      tick && !(|hit) && !counter_reset |=> timer_count == $past(timer_count) + 32'h1
   ) else $error("timer did not advance on tick");

   a_prescale_wrap: assert property (
      tick |=> prescale_count == 32'h0
   ) else $error("prescaler did not wrap on tick");

   a_prescale_step: assert property (
      running && !tick |=> prescale_count == $past(prescale_count) + 32'h1
   ) else $error("prescaler did not step");

   a_prescale_idle: assert property (
      !running && !counter_reset |=> $stable(prescale_count)
   ) else $error("prescaler moved while idle");

   a_no_tick_hold: assert property (
      !tick && !counter_reset |=> timer_count == $past(timer_count)
   ) else $error("timer moved without tick");

   a_count_clear: assert property (
      counter_reset |=> timer_count == 32'h0 && prescale_count == 32'h0
   ) else $error("count reset did not clear");

   // Match actions on the count; a halted count must not creep on
   a_reset_match: assert property (
      (|hit_reset) && !counter_reset |=> timer_count == 32'h0
   ) else $error("reset on match failed");

   a_stop_match: assert property (
      (|hit_stop) |=> halted ##0 !tick
   ) else $error("stop on match failed");

   a_halt_freeze: assert property (
      halted && !counter_reset |=> $stable(timer_count)
   ) else $error("halted count moved");

   a_halt_release: assert property (
      !counter_enable |=> !halted
   ) else $error("halt not released by enable");

   a_cont_match: assert property (
      hit[0] && !(|hit_reset) && !(|hit_stop) && !counter_reset
         |=> timer_count == $past(timer_count) + 32'h1 && !halted
   ) else $error("continuous match disturbed count");

   a_match_flag: assert property (
      hit[3] |=> irq_flags[3]
   ) else $error("match flag not set");

   // Match outputs move only on their own match
   a_out_low: assert property (
      hit[0] && match_cfg[0].ext_act == cmt_pkg::CMT_MACT_LOW |=> !match_output[0]
   ) else $error("match output not driven low");

   a_out_high: assert property (
      hit[2] && match_cfg[2].ext_act == cmt_pkg::CMT_MACT_HIGH |=> match_output[2]
   ) else $error("match output not driven high");

   a_out_hold: assert property (
      hit[3] && match_cfg[3].ext_act == cmt_pkg::CMT_MACT_NONE |=> $stable(match_output[3])
   ) else $error("match output moved on no action");

   a_toggle_out: assert property (
      hit[1] && match_cfg[1].ext_act == cmt_pkg::CMT_MACT_TOGGLE
         |=> match_output[1] != $past(match_output[1])
   ) else $error("match output did not toggle");

   a_out_quiet: assert property (
      !(|hit) |=> $stable(match_output)
   ) else $error("match output moved without a match");

   // Flags and request; set must beat clear so no event is lost
   a_flag_sticky: assert property (
      irq_flags[4] && !irq_clear[4] |=> irq_flags[4]
   ) else $error("capture flag lost");

   a_flag_clear: assert property (
      irq_clear[0] && !hit[0] |=> !irq_flags[0]
   ) else $error("match flag not cleared");

   a_set_wins: assert property (
      hit[1] && irq_clear[1] |=> irq_flags[1]
   ) else $error("clear beat a new match");

   a_cap_flag: assert property (
      cap_evt[0] |=> irq_flags[4]
   ) else $error("capture flag not set");

   a_irq_gated: assert property (
      cap_evt[2] && cap_cfg[2].irq_en |=> irq_req
   ) else $error("enabled capture gave no request");

   a_irq_masked: assert property (
      irq_flags[7] && !cap_cfg[3].irq_en && (irq_flags[6:0] & flag_en[6:0]) == 7'h00
         |-> !irq_req
   ) else $error("disabled capture raised request");
endmodule // cmt_timer

// file: cmt_pin_model.sv
// Pin-side model: capture input drivers and match output watcher
`timescale 1ns/1ps

module cmt_pin_model (
   // Clock
   input  wire logic        sys_clk,
   // Bench requests
   input  wire logic [3:0]  pin_req,
   input  wire logic        clr_cnt,
   // Timer pins
   output logic [3:0]       capture_input,
   input  wire logic [3:0]  match_output,
   // Observation
   output logic [31:0]      toggles
);
   logic prev_out;

   // Pins launched off the edge and held until the next request
   always_ff @(posedge sys_clk) begin
      capture_input <= pin_req;
      prev_out      <= match_output[1];
      if (clr_cnt) begin
         toggles <= 32'h0;
      end else if (match_output[1] !== prev_out) begin
         toggles <= toggles + 32'h1;
      end
   end
endmodule // cmt_pin_model

// file: cmt_timer_tb.sv
// Self-checking bench for the capture and match timer
`timescale 1ns/1ps

module cmt_timer_tb;
   logic        sys_clk = 0, rst = 1, counter_enable = 0, counter_reset = 0, clr_cnt = 0;
   logic [31:0] prescale_max = 0, timer_count, prescale_count, toggles, got, t0, m, p;
   logic [31:0] match_value [4];
   logic [31:0] cap_value [4];
   cmt_pkg::cmt_match_cfg_t match_cfg [4];
   cmt_pkg::cmt_cap_cfg_t   cap_cfg [4];
   logic [7:0]  irq_clear = 0, irq_flags, prev_flags;
   logic        halted, irq_req;
   logic [3:0]  capture_input, match_output, pin_req = 0;
   logic [31:0] exp_q [$];
   int          num_errors = 0, tests_run = 0, seed = 32'haeaf;

   cmt_timer i_cmt_timer (.sys_clk(sys_clk), .rst(rst), .counter_enable(counter_enable),
      .counter_reset(counter_reset), .prescale_max(prescale_max), .match_value(match_value),
      .match_cfg(match_cfg), .cap_cfg(cap_cfg), .irq_clear(irq_clear),
      .timer_count(timer_count), .prescale_count(prescale_count), .cap_value(cap_value),
      .irq_flags(irq_flags), .halted(halted), .irq_req(irq_req),
      .capture_input(capture_input), .match_output(match_output));
   cmt_pin_model i_cmt_pin_model (.sys_clk(sys_clk), .pin_req(pin_req), .clr_cnt(clr_cnt),
      .capture_input(capture_input), .match_output(match_output), .toggles(toggles));

   always #12.5 sys_clk = ~sys_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("errors=%0d checks=%0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic clr_flags(input logic [7:0] mask);
      @(posedge sys_clk) irq_clear <= mask;
      @(posedge sys_clk) irq_clear <= 8'h00;
   endtask

   // One pin step: note captures, change pins, then check the request
   task automatic cap_step(input logic [3:0] pins, input logic [3:0] caps, input logic irq);
      for (int i = 0; i < 4; i++) if (caps[i]) exp_q.push_back(m);
      @(posedge sys_clk) pin_req <= pins;
      repeat (8) @(posedge sys_clk);
      #1 check(irq_req, irq);
      clr_flags(8'hF0);
   endtask

   // A newly set flag pulls the oldest note; stale notes or no note both fail
   always @(posedge sys_clk) begin
      if (!rst) for (int i = 0; i < 8; i++) if (irq_flags[i] && !prev_flags[i]) begin
         got = (i < 4) ? timer_count : cap_value[i-4];
         if (exp_q.size() != 0) check(got, exp_q.pop_front());
         else check(exp_q.size(), 32'h1);
      end
      prev_flags <= irq_flags;
   end

   // Watchdog sized well past the longest sequence
   initial begin
      #(25 * 5000);
      num_errors++;
      test_done();
   end

   initial begin
      m = 32'd8 + ($random(seed) & 32'h1F);
      p = $random(seed) & 32'h3;
      for (int i = 0; i < 4; i++) begin
         match_value[i] = 32'hFFFF_FFFF;
         match_cfg[i] = '0;
      end
      match_value[0] = m;
      match_cfg[0] = '{1'b1, 1'b1, 1'b0, cmt_pkg::CMT_MACT_HIGH};
      cap_cfg = '{'{1'b1, 1'b1, 1'b0}, '{1'b1, 1'b1, 1'b1}, '{1'b1, 1'b0, 1'b1}, '{1'b0, 1'b1, 1'b0}};
      repeat (6) @(posedge sys_clk);
      rst <= 0;
      exp_q.push_back(m);
      @(posedge sys_clk) prescale_max <= p;
      counter_enable <= 1;
      repeat (2) @(posedge sys_clk);
      #1 t0 = timer_count;
      repeat (4 * (p + 1)) @(posedge sys_clk);
      #1 check(timer_count, t0 + 32'd4);
      repeat ((m + 2) * (p + 1) + 10) @(posedge sys_clk);
      #1 check(timer_count, m);
      check({halted, irq_req, match_output}, {2'b11, 4'h1});
      check(prescale_count, 32'h0);
      clr_flags(8'hFF);
      #1 check({irq_req, irq_flags}, 9'h0);
      cap_step(4'b1000, 4'b1000, 1'b0);
      cap_step(4'b1111, 4'b0011, 1'b1);
      cap_step(4'b0000, 4'b0110, 1'b1);
      check(exp_q.size(), 32'h0);
      // Count restart: actions table, reset-on-match period of six
      @(posedge sys_clk) counter_enable <= 0;
      counter_reset <= 1;
      prescale_max <= 0;
      match_value <= '{32'd2, 32'd5, 32'd4, 32'd1};
      match_cfg <= '{'{1'b1, 1'b0, 1'b0, cmt_pkg::CMT_MACT_LOW},
         '{1'b1, 1'b0, 1'b1, cmt_pkg::CMT_MACT_TOGGLE},
         '{1'b0, 1'b0, 1'b0, cmt_pkg::CMT_MACT_HIGH}, '{1'b0, 1'b0, 1'b0, cmt_pkg::CMT_MACT_NONE}};
      clr_flags(8'hFF);
      exp_q = '{32'd2, 32'd3, 32'd5, 32'd0};
      @(posedge sys_clk) counter_enable <= 1;
      counter_reset <= 0;
      repeat (12) @(posedge sys_clk);
      clr_cnt <= 1;
      @(posedge sys_clk) clr_cnt <= 0;
      repeat (60) @(posedge sys_clk);
      #1 check(toggles, 32'd10);
      check(match_output & 4'b1101, 4'b0100);
      check({irq_req, irq_flags}, 9'h10F);
      check(exp_q.size(), 32'h0);
      test_done();
   end
endmodule // cmt_timer_tb
